// >>> design/ast_top.v
// Asynchronous serial transceiver: baud generator, transmitter, receiver.
// Assumes control bits are held steady by software while frames are moving.
//
// Overview of operation
// R01: Transmitter and receiver concurrent, shared settings
// R02: Eight data bits, least significant first
// R03: Optional even or odd parity, checked
// R04: One start bit, one or two stops
// R05: Sixteen-bit divisor from high/low bytes
// R06: Separate transmit and receive enables
// R07: Holding-empty flag; software waits for one
// R08: Held byte moves to shifter automatically
// R09: Ready flag high while data held
// R10: Transmit request whenever holding register empty and transmitter enabled
// R11: Software never mixes parity with multidrop
// R12: Ninth bit value sent as written
// R13: Multidrop switches both directions to nine bits
// R14: Flow control enable gates clear-to-send
// R15: Framing, parity, overrun, break status bits
// R16: Receive request separate from transmit request
// R17: Receive request on data+errors or errors
// R18: Scheme field selects address matching
// R19: Ninth position carries address flag
// R20: Transmit write clears holding-empty flag
// R21: Read clears ready unless next waiting
`include "ast_map.vh"
`default_nettype none

module ast_top (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  baud_hi,          // Divisor high byte
  input  wire [7:0]  baud_lo,          // Divisor low byte
  input  wire        tx_enable_bit,    // Transmitter on
  input  wire        rx_enable_bit,    // Receiver on
  input  wire        parity_on_bit,    // Parity on
  input  wire        parity_odd,       // Odd sense when high
  input  wire        two_stop,         // Two stop bits when high
  input  wire        flow_ctrl_on,     // Honour clear-to-send
  input  wire        multidrop_on,     // Nine-bit mode
  input  wire        tx_ninth_bit,     // Outgoing address flag
  input  wire [1:0]  multidrop_scheme, // Address matching scheme
  input  wire        rx_err_only_irq,  // Receive request on errors only
  input  wire [7:0]  addr_compare,     // Own network address
  input  wire [7:0]  tx_data,          // Byte to send
  input  wire        tx_write,         // Write strobe for tx_data
  output reg         tx_holding_empty, // Holding register free
  output wire        tx_irq,           // Transmit request
  output wire [7:0]  rx_data,          // Received byte
  input  wire        rx_read,          // Read strobe for rx_data
  output wire        rx_byte_ready,    // Received byte waiting
  output wire        rx_ninth,         // Address flag of byte
  output wire        rx_new_frame,     // First data of matched frame, MATCH and QUIET schemes
  output wire        framing_err,      // Stop bit was low
  output wire        parity_err,       // Parity mismatch
  output wire        break_det,        // Whole frame low
  output reg         overrun_err,      // Byte lost, buffer full
  output wire        rx_irq,           // Receive request
  output reg         txd,              // Serial out, idle high
  input  wire        rxd,              // Serial in
  input  wire        cts_n             // Clear to send, active low
);

  // Transmit states
  localparam TX_IDLE  = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA  = 3'h2;
  localparam TX_NINE  = 3'h3;
  localparam TX_STOP  = 3'h4;
  // Receive states
  localparam RX_IDLE  = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA  = 3'h2;
  localparam RX_NINE  = 3'h3;
  localparam RX_STOP  = 3'h4;
  localparam RX_HOLD  = 3'h5;

  reg  [15:0] brg_cnt;                 // Baud down-counter
  reg         tick;                    // One-cycle 16x enable
  reg  [1:0]  cts_sync;                // Clear-to-send synchroniser
  reg  [1:0]  rxd_sync;                // Serial input synchroniser
  reg  [7:0]  tx_hold;                 // Holding register
  reg         tx_hold_nine;            // Ninth bit stored with byte
  reg  [2:0]  tx_state;
  reg  [3:0]  tx_sub;                  // Ticks inside a bit
  reg  [2:0]  tx_idx;                  // Data bit index
  reg  [7:0]  tx_shift;                // Shift register
  reg         tx_nine;                 // Ninth bit being sent
  reg         tx_stop2;                // Second stop in progress
  reg  [2:0]  rx_state;
  reg  [3:0]  rx_sub;
  reg  [2:0]  rx_idx;
  reg  [7:0]  rx_shift;
  reg         rx_nine;
  reg         rx_done;                 // Character complete pulse
  reg  [7:0]  rx_byte;                 // Completed byte
  reg         rx_cnine;                // Completed ninth bit
  reg         rx_frm;                  // Completed framing error
  reg         rx_brk;                  // Completed break
  reg         in_frame;                // Address matched
  reg         first_data;              // Next data opens a frame

  wire [15:0] divisor  = {baud_hi, baud_lo};
  wire        has_nine = multidrop_on | parity_on_bit;
  wire        rx_line  = rxd_sync[1];
  wire        cts_ok   = ~flow_ctrl_on | ~cts_sync[1];
  wire [`AST_ENTRY_W-1:0] head;        // Oldest buffered entry
  wire        buf_ready;               // Buffer has room

  // R05: divisor ticks
  // Divisor of zero or one ticks every clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      brg_cnt <= `AST_DIV_RST;
      tick    <= 1'b0;
    end else if (brg_cnt <= `AST_DIV_ONE) begin
      brg_cnt <= divisor;
      tick    <= 1'b1;
    end else begin
      brg_cnt <= brg_cnt - `AST_DIV_ONE;
      tick    <= 1'b0;
    end
  end

  // Pin synchronisers, first stage read only by second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cts_sync <= 2'h3;
      rxd_sync <= 2'h3;
    end else begin
      cts_sync <= {cts_sync[0], cts_n};
      rxd_sync <= {rxd_sync[0], rxd};
    end
  end

  // R07: holding flag
  // Writes while full are dropped; software polls the flag first
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_holding_empty <= 1'b1;
      tx_hold          <= `AST_BYTE_RST;
      tx_hold_nine     <= 1'b0;
    end else if (tx_write && tx_holding_empty) begin
      // R20: write clears flag
      tx_holding_empty <= 1'b0;
      tx_hold          <= tx_data;
      // R12: ninth bit latched
      tx_hold_nine     <= tx_ninth_bit;
    end else if (tx_state == TX_IDLE && !tx_holding_empty && tx_enable_bit && cts_ok) begin
      // R08: automatic transfer
      tx_holding_empty <= 1'b1;
    end
  end

  // R10: empty raises request
  assign tx_irq = tx_holding_empty & tx_enable_bit;

  // Transmit sequencer
  // R01: independent of receiver
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_sub   <= `AST_SUB_ZERO;
      tx_idx   <= `AST_BIT_ZERO;
      tx_shift <= `AST_BYTE_RST;
      tx_nine  <= 1'b0;
      tx_stop2 <= 1'b0;
      txd      <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          txd <= 1'b1;
          // R06: gated start
          // R14: clear-to-send hold-off
          if (!tx_holding_empty && tx_enable_bit && cts_ok) begin
            tx_shift <= tx_hold;
            // R19: address flag or parity
            // R03: parity sense
            tx_nine  <= multidrop_on ? tx_hold_nine : (parity_odd ^ (^tx_hold));
            tx_sub   <= `AST_SUB_ZERO;
            tx_idx   <= `AST_BIT_ZERO;
            tx_stop2 <= 1'b0;
            // R04: low start bit
            txd      <= 1'b0;
            tx_state <= TX_START;
          end
        end
        TX_START, TX_DATA, TX_NINE, TX_STOP: begin
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            // Bit boundary after sixteen ticks
            if (tx_sub == `AST_OVS_LAST) begin
              case (tx_state)
                TX_START: begin
                  // R02: LSB first
                  txd      <= tx_shift[0];
                  tx_state <= TX_DATA;
                end
                TX_DATA: begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_idx   <= tx_idx + 3'h1;
                  if (tx_idx != `AST_LAST_BIT) begin
                    txd <= tx_shift[1];
                  // R13: nine bits when multidrop
                  end else if (has_nine) begin
                    txd      <= tx_nine;
                    tx_state <= TX_NINE;
                  end else begin
                    txd      <= 1'b1;
                    tx_state <= TX_STOP;
                  end
                end
                TX_NINE: begin
                  txd      <= 1'b1;
                  tx_state <= TX_STOP;
                end
                default: begin
                  // R04: one or two stops
                  if (two_stop && !tx_stop2) begin
                    tx_stop2 <= 1'b1;
                  end else begin
                    tx_state <= TX_IDLE;
                  end
                end
              endcase
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receive sequencer, sampling mid-bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_sub   <= `AST_SUB_ZERO;
      rx_idx   <= `AST_BIT_ZERO;
      rx_shift <= `AST_BYTE_RST;
      rx_nine  <= 1'b0;
      rx_done  <= 1'b0;
      rx_byte  <= `AST_BYTE_RST;
      rx_cnine <= 1'b0;
      rx_frm   <= 1'b0;
      rx_brk   <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          // R06: receive gated
          if (rx_enable_bit && !rx_line) begin
            rx_sub   <= `AST_SUB_ZERO;
            rx_nine  <= 1'b0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            // Half a bit in: a high line was a glitch
            if (rx_sub == `AST_OVS_MID) begin
              rx_sub   <= `AST_SUB_ZERO;
              rx_idx   <= `AST_BIT_ZERO;
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA, RX_NINE, RX_STOP: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `AST_OVS_LAST) begin
              case (rx_state)
                RX_DATA: begin
                  // R02: LSB arrives first
                  rx_shift <= {rx_line, rx_shift[7:1]};
                  rx_idx   <= rx_idx + 3'h1;
                  if (rx_idx == `AST_LAST_BIT) begin
                    rx_state <= has_nine ? RX_NINE : RX_STOP;
                  end
                end
                RX_NINE: begin
                  rx_nine  <= rx_line;
                  rx_state <= RX_STOP;
                end
                default: begin
                  // R15: framing and break
                  rx_done  <= 1'b1;
                  rx_byte  <= rx_shift;
                  rx_cnine <= rx_nine;
                  rx_frm   <= ~rx_line;
                  rx_brk   <= ~rx_line & ~(|rx_shift) & ~rx_nine;
                  // A low stop waits for idle so a break is seen once
                  rx_state <= rx_line ? RX_IDLE : RX_HOLD;
                end
              endcase
            end
          end
        end
        RX_HOLD: begin
          if (rx_line) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // R03: receive parity check
  wire par_bad  = parity_on_bit & ~multidrop_on & (rx_cnine != (parity_odd ^ (^rx_byte)));
  wire any_err  = rx_frm | rx_brk | par_bad;
  wire is_addr  = multidrop_on & rx_cnine;
  wire match    = (rx_byte == addr_compare);
  reg  present;                        // Byte offered to software
  reg  mark_new;                       // Byte opens a matched frame, MATCH or QUIET scheme

  // R18: address scheme
  always @* begin
    present  = 1'b1;
    mark_new = 1'b0;
    if (multidrop_on) begin
      case (multidrop_scheme)
        `AST_MD_ALL:   present = 1'b1;
        `AST_MD_ADDR:  present = is_addr;
        `AST_MD_MATCH: present = is_addr ? match : in_frame;
        `AST_MD_QUIET: present = is_addr ? 1'b0 : in_frame;
        default:       present = 1'b1;
      endcase
      mark_new = ~is_addr & in_frame & first_data & multidrop_scheme[1];
    end
  end

  // Frame tracking for the automatic schemes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_frame   <= 1'b0;
      first_data <= 1'b0;
    end else if (rx_done && is_addr) begin
      in_frame   <= match;
      first_data <= match;
    end else if (rx_done && present) begin
      first_data <= 1'b0;
    end
  end

  wire push = rx_done & (present | any_err);
  wire [`AST_ENTRY_W-1:0] entry = {mark_new, rx_cnine, rx_brk, par_bad, rx_frm, rx_byte};

  // R15: overrun sticky
  // A loss in the read cycle still sets the flag
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_err <= 1'b0;
    end else if (push && !buf_ready) begin
      overrun_err <= 1'b1;
    end else if (rx_read) begin
      overrun_err <= 1'b0;
    end
  end

  // R21: buffered ready flag
  // Two entries ride out one slow read before overrun
  ast_buf2 #(
    .W (`AST_ENTRY_W)
  ) u_rx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_data   (entry),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .out_data  (head),
    .out_valid (rx_byte_ready),
    .out_ready (rx_read)
  );

  // R09: ready while held
  assign rx_data      = head[`AST_F_DATA_HI:0];
  assign framing_err  = rx_byte_ready & head[`AST_F_FRM];
  assign parity_err   = rx_byte_ready & head[`AST_F_PAR];
  assign break_det    = rx_byte_ready & head[`AST_F_BRK];
  assign rx_ninth     = rx_byte_ready & head[`AST_F_NINE];
  assign rx_new_frame = rx_byte_ready & head[`AST_F_NEWF];

  // R16: separate receive request
  // R17: errors-only option
  assign rx_irq = overrun_err |
                  (rx_byte_ready & (~rx_err_only_irq | (|head[`AST_F_BRK:`AST_F_FRM])));

endmodule // ast_top

`default_nettype wire

// >>> include/ast_map.vh
// Constants of the asynchronous serial transceiver: frame timing,
// receive entry layout, multidrop schemes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef AST_MAP_VH
`define AST_MAP_VH

// Oversampling: sixteen baud ticks per bit
`define AST_OVS_LAST   4'hf
`define AST_OVS_MID    4'h7
`define AST_SUB_ZERO   4'h0
`define AST_LAST_BIT   3'h7
`define AST_BIT_ZERO   3'h0
`define AST_DIV_ONE    16'h0001

// Receive entry layout held in the two-entry buffer
`define AST_ENTRY_W    13
`define AST_F_DATA_HI  7
`define AST_F_FRM      8
`define AST_F_PAR      9
`define AST_F_BRK      10
`define AST_F_NINE     11
`define AST_F_NEWF     12

// Multidrop address schemes
`define AST_MD_ALL     2'h0
`define AST_MD_ADDR    2'h1
`define AST_MD_MATCH   2'h2
`define AST_MD_QUIET   2'h3

// Reset values
`define AST_BYTE_RST   8'h00
`define AST_DIV_RST    16'h0000

`endif

// >>> design/ast_buf2.v
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`default_nettype none

module ast_buf2 #(
  parameter W = 13                    // Entry width
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);

  reg [W-1:0] mem [0:1];              // Storage for two entries
  reg         wr_ptr;                 // Next slot to fill
  reg         rd_ptr;                 // Oldest slot
  reg [1:0]   count;                  // Entries held

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Full and empty come straight from the count, never guessed
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];

  // Storage write, one slot per generated entry
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_slot
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          mem[i] <= {W{1'b0}};
        end else if (push && (wr_ptr == i)) begin
          mem[i] <= in_data;
        end
      end
    end
  endgenerate

  // Pointers and occupancy
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      // Simultaneous push and pop keep the count
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule // ast_buf2

`default_nettype wire

// >>> test/ast_chk_sva.sv
// Checker for the serial transceiver: port timing relations.
// Assumes a bind onto ast_top; one clock, async reset.
`default_nettype none

module ast_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_enable_bit,
  input wire logic flow_ctrl_on,
  input wire logic cts_n,
  input wire logic tx_write,
  input wire logic tx_holding_empty,
  input wire logic tx_irq,
  input wire logic txd,
  input wire logic rx_read,
  input wire logic rx_byte_ready,
  input wire logic rx_ninth,
  input wire logic rx_new_frame,
  input wire logic framing_err,
  input wire logic parity_err,
  input wire logic break_det,
  input wire logic overrun_err,
  input wire logic rx_irq,
  input wire logic rx_err_only_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  hold_clear_a: assert property (
    tx_write && tx_holding_empty |=> !tx_holding_empty) else $error("empty kept after write");
  hold_keep_a: assert property (
    tx_holding_empty && !tx_write |=> tx_holding_empty) else $error("empty dropped alone");
  start_load_a: assert property (
    $rose(tx_holding_empty) |-> !txd && $past(txd) && $past(tx_enable_bit))
    else $error("load without start bit");
  start_width_a: assert property (
    $rose(tx_holding_empty) |-> (!txd) [*8]) else $error("start bit too short");
  cts_gate_a: assert property (
    $rose(tx_holding_empty) && flow_ctrl_on |-> !$past(cts_n, 3)) else $error("start while held");
  tx_req_a: assert property (
    tx_irq == (tx_holding_empty && tx_enable_bit)) else $error("transmit request wrong");
  rx_req_a: assert property (
    rx_irq == (overrun_err || (rx_byte_ready && (!rx_err_only_irq || framing_err
      || parity_err || break_det)))) else $error("receive request wrong");
  ready_keep_a: assert property (
    rx_byte_ready && !rx_read |=> rx_byte_ready) else $error("ready lost unread");
  flag_gate_a: assert property (
    !rx_byte_ready |-> !(framing_err || parity_err || break_det || rx_ninth || rx_new_frame))
    else $error("flag without data");
  brk_frm_a: assert property (
    break_det |-> framing_err) else $error("break without framing");
  ovr_keep_a: assert property (
    overrun_err && !rx_read |=> overrun_err) else $error("overrun dropped unread");
endmodule // ast_chk

bind ast_top ast_chk ast_chk_i (
  .clk(clk), .rst(rst), .tx_enable_bit(tx_enable_bit), .flow_ctrl_on(flow_ctrl_on),
  .cts_n(cts_n), .tx_write(tx_write), .tx_holding_empty(tx_holding_empty),
  .tx_irq(tx_irq), .txd(txd), .rx_read(rx_read), .rx_byte_ready(rx_byte_ready),
  .rx_ninth(rx_ninth), .rx_new_frame(rx_new_frame), .framing_err(framing_err),
  .parity_err(parity_err), .break_det(break_det), .overrun_err(overrun_err),
  .rx_irq(rx_irq), .rx_err_only_irq(rx_err_only_irq)
);

`default_nettype wire

// >>> test/ast_node.sv
// Remote serial node: sends frames on rxd, decodes frames from txd.
// Assumes bit time in clocks set by the bench to match the divisor.
`default_nettype none

module ast_node (
  input wire logic  clk,     // System clock
  input wire logic  txd,     // Line from the device
  input wire logic  nine_en, // Ninth bit present
  output var logic  rxd,     // Line to the device
  output var logic  cts_n    // Our clear to send
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bt = 16;    // Clocks per bit
  logic [9:0] got_q[$];   // Decoded {stop, ninth, data}
  logic [7:0] rd;         // Byte being decoded
  logic       rn;         // Ninth being decoded

  // Idle line high, ready to accept
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end

  task automatic send(input logic [7:0] d, input logic nine, input logic stop_v);
    logic [11:0] f;
    @(posedge clk);
    f = nine_en ? {1'b1, stop_v, nine, d, 1'b0} : {2'b11, stop_v, d, 1'b0};
    // Format read once settings land
    for (int i = 0; i < 12; i++) begin
      rxd <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask

  always begin
    @(negedge txd);
    repeat (bt / 2) @(posedge clk);
    // Start must still be low
    if (!txd) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bt) @(posedge clk);
        rd[i] = txd;
      end
      rn = 1'b0;
      if (nine_en) begin
        repeat (bt) @(posedge clk);
        rn = txd;
      end
      repeat (bt) @(posedge clk);
      got_q.push_back({txd, rn, rd});
    end
  end
endmodule // ast_node

`default_nettype wire

// >>> test/ast_top_tb.sv
// Self-checking bench for the serial transceiver top.
// Assumes ast_node as the far end and the bound checker.
`default_nettype none

module ast_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst = 1'b1; // Clock, reset
  logic [7:0] baud_hi = 8'h00, baud_lo = 8'h01;   // One tick a clock
  logic       tx_enable_bit = 1'b1, rx_enable_bit = 1'b1;
  logic       parity_on_bit = 1'b0, parity_odd = 1'b0, two_stop = 1'b0;
  logic       flow_ctrl_on = 1'b0, multidrop_on = 1'b0, tx_ninth_bit = 1'b0;
  logic [1:0] multidrop_scheme = 2'h0; // Address scheme
  logic       rx_err_only_irq = 1'b0;  // Request mode
  logic [7:0] addr_compare = 8'h5a, tx_data = 8'h00, rx_data;
  logic       tx_write = 1'b0, rx_read = 1'b0;    // Strobes
  logic       tx_holding_empty, tx_irq, rx_byte_ready, rx_ninth, rx_new_frame;
  logic       framing_err, parity_err, break_det, overrun_err, rx_irq, txd, rxd, cts_n;
  int         err_total = 0, tests_run = 0; // Counters
  logic [9:0] got;                          // Frame from far end

  // 25 ns period
  always #12.5 clk = ~clk;

  ast_top ast_top_i (
    .clk(clk), .rst(rst), .baud_hi(baud_hi), .baud_lo(baud_lo),
    .tx_enable_bit(tx_enable_bit), .rx_enable_bit(rx_enable_bit),
    .parity_on_bit(parity_on_bit), .parity_odd(parity_odd), .two_stop(two_stop),
    .flow_ctrl_on(flow_ctrl_on), .multidrop_on(multidrop_on), .tx_ninth_bit(tx_ninth_bit),
    .multidrop_scheme(multidrop_scheme), .rx_err_only_irq(rx_err_only_irq),
    .addr_compare(addr_compare), .tx_data(tx_data), .tx_write(tx_write),
    .tx_holding_empty(tx_holding_empty), .tx_irq(tx_irq), .rx_data(rx_data),
    .rx_read(rx_read), .rx_byte_ready(rx_byte_ready), .rx_ninth(rx_ninth),
    .rx_new_frame(rx_new_frame), .framing_err(framing_err), .parity_err(parity_err),
    .break_det(break_det), .overrun_err(overrun_err), .rx_irq(rx_irq), .txd(txd),
    .rxd(rxd), .cts_n(cts_n));
  ast_node ast_node_i (.clk(clk), .txd(txd), .nine_en(parity_on_bit | multidrop_on),
    .rxd(rxd), .cts_n(cts_n));

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Timeout: count, stop
  task automatic give_up();
    err_total++;
    close_out();
  endtask

  // Write once the holding register is free
  task automatic wr(input logic [7:0] b);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (tx_holding_empty !== 1'b1 && k < 800);
    if (k >= 800) give_up();
    @(posedge clk);
    tx_data <= b;
    tx_write <= 1'b1;
    @(posedge clk);
    tx_write <= 1'b0;
    @(negedge clk);
    chk(tx_holding_empty, 1'b0);
  endtask

  // Next frame seen by the far end
  task automatic tx_got();
    int k;
    for (k = 0; k < 900 && ast_node_i.got_q.size() == 0; k++) @(negedge clk);
    if (k >= 900) give_up();
    got = ast_node_i.got_q.pop_front();
  endtask

  task automatic wait_rx();
    int k;
    for (k = 0; k < 400 && rx_byte_ready !== 1'b1; k++) @(negedge clk);
    if (k >= 400) give_up();
  endtask

  // One-cycle pop, then settle
  task automatic pop();
    @(posedge clk);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    @(negedge clk);
  endtask

  task automatic sc_reset();
    chk({txd, tx_holding_empty, rx_byte_ready}, 3'h6);
    chk(tx_irq, 1'b1);
  endtask

  // Back-to-back bytes per format: {parity, odd, multidrop, ninth}
  task automatic sc_tx();
    logic [3:0] cfg [5] = '{4'h0, 4'h8, 4'hc, 4'h3, 4'h2};
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {parity_on_bit, parity_odd, multidrop_on, tx_ninth_bit} <= cfg[i];
      two_stop <= (i == 1);
      d = 8'h96 + 8'(i);
      wr(d);
      wr(~d);
      for (int j = 0; j < 2; j++) begin
        tx_got();
        chk(got, {1'b1, cfg[i][1] ? cfg[i][0] : cfg[i][3] & (^d ^ cfg[i][2]), d});
        d = ~d;
      end
      repeat (48) @(posedge clk);
    end
    {parity_on_bit, multidrop_on, two_stop} <= 3'h0;
  endtask

  // Enable and clear-to-send hold-off
  task automatic sc_gate();
    @(posedge clk);
    tx_enable_bit <= 1'b0;
    ast_node_i.cts_n <= 1'b1;
    wr(8'h55);
    repeat (100) @(negedge clk);
    chk({tx_holding_empty, txd, tx_irq}, 3'h2);
    @(posedge clk);
    tx_enable_bit <= 1'b1;
    flow_ctrl_on <= 1'b1;
    repeat (100) @(negedge clk);
    chk({tx_holding_empty, txd}, 2'h1);
    ast_node_i.cts_n <= 1'b0;
    tx_got();
    chk(got, 10'h255);
    flow_ctrl_on <= 1'b0;
    ast_node_i.cts_n <= 1'b1;
    wr(8'haa);
    tx_got();
    chk(got, 10'h2aa);
    ast_node_i.cts_n <= 1'b0;
  endtask

  // Formats and faults: {parity, odd, bad parity, stop level}
  task automatic sc_rx();
    logic [7:0] dv [6] = '{8'ha5, 8'h3c, 8'h81, 8'h3c, 8'h5a, 8'h00};
    logic [3:0] fv [6] = '{4'h1, 4'h9, 4'hd, 4'hb, 4'h0, 4'h0};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      {parity_on_bit, parity_odd} <= (i < 6) ? fv[i][3:2] : 2'h0;
      two_stop <= (i == 1);
      rx_err_only_irq <= (i == 6);
      if (i < 6) ast_node_i.send(dv[i], ^dv[i] ^ fv[i][2] ^ fv[i][1], fv[i][0]);
      else ast_node_i.send(8'ha5, 1'b0, 1'b1);
      wait_rx();
      chk(rx_data, (i < 6) ? dv[i] : 8'ha5);
      if (i < 6) begin
        chk({framing_err, parity_err, break_det}, {!fv[i][0], fv[i][1], dv[i] == 0 && !fv[i][0]});
      end
      chk(rx_irq, i < 6);
      pop();
      chk(rx_byte_ready, 1'b0);
    end
    rx_err_only_irq <= 1'b0;
  endtask

  // Fill both entries, lose the third, drain in order
  task automatic sc_ovr();
    ast_node_i.send(8'h11, 1'b0, 1'b1);
    ast_node_i.send(8'h22, 1'b0, 1'b1);
    ast_node_i.send(8'h33, 1'b0, 1'b1);
    @(negedge clk);
    chk({overrun_err, rx_irq, rx_data}, 10'h311);
    pop();
    chk({rx_byte_ready, overrun_err, rx_data}, 10'h222);
    pop();
    chk(rx_byte_ready, 1'b0);
  endtask

  // Every scheme against address, data, foreign address, data
  task automatic sc_md();
    logic [7:0] bv [4] = '{8'h5a, 8'h11, 8'h33, 8'h22};
    logic [3:0] mk [4] = '{4'hf, 4'h5, 4'h3, 4'h2};
    @(posedge clk);
    multidrop_on <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      multidrop_scheme <= 2'(s);
      for (int j = 0; j < 4; j++) begin
        ast_node_i.send(bv[j], j % 2 == 0, 1'b1);
        @(negedge clk);
        chk(rx_byte_ready, mk[s][j]);
        if (mk[s][j]) begin
          chk({rx_ninth, rx_new_frame, rx_data}, {j % 2 == 0, j == 1 && s >= 2, bv[j]});
          pop();
        end
      end
    end
    multidrop_on <= 1'b0;
  endtask

  // Both directions at once, divisor of two
  task automatic sc_duplex();
    @(posedge clk);
    baud_lo <= 8'h02;
    ast_node_i.bt = 32;
    fork
      ast_node_i.send(8'hc3, 1'b0, 1'b1);
      wr(8'h3c);
    join
    wait_rx();
    chk(rx_data, 8'hc3);
    pop();
    tx_got();
    chk(got, 10'h23c);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    sc_reset();
    sc_tx();
    sc_gate();
    sc_rx();
    sc_ovr();
    sc_md();
    sc_duplex();
    close_out();
  end
endmodule // ast_top_tb

`default_nettype wire
